// >>> common/sfi_pkg.sv
// package: constants, types and helpers for the serial flash interface states
// What this block does
// - chip select high means interface idle
// - idle ignores all but select and the reset line
// - chip select falling starts instruction phase
// - optional line-three reset, quad mode needs select high
// - reset pulse, reset process, hold, then idle
// - power-up interval silent, then idle
// - sleep entry only while write-in-progress is clear
// - sleep ignores all but wake and the reset line; wake, delay, idle
// - output lanes follow width, else undriven
// - sdr latency cycles undriven, inputs ignored
// - ddr latency may drive learning pattern
// - lowest bit of group on line zero
// - non-read command needs eight-bit boundary
package sfi_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_PU_US       = 300;
  localparam int T_RP_NS       = 200;
  localparam int T_RPH_US      = 35;
  localparam int T_RH_NS       = 50;
  localparam int T_RES_US      = 20;
  // least times, rounded up to whole cycles
  localparam int PU_CYCLES_DEF  = (T_PU_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CYCLES_DEF  = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RPH_CYCLES_DEF = (T_RPH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RH_CYCLES_DEF  = (T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RES_CYCLES_DEF = (T_RES_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // command framing
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SLEEP  = 8'hb9;
  localparam logic [7:0] CMD_WAKE   = 8'hab;
  localparam logic [5:0] INSTR_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS  = 6'h18;
  localparam logic [5:0] MODE_BITS  = 6'h08;
  localparam logic [7:0] PAD_BYTE   = 8'hff;
  localparam int         FIFO_DEPTH = 32;
  localparam int         BYTE_W     = 8;

  // line enables per width
  localparam logic [3:0] OE_NONE   = 4'h0;
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_DUAL   = 4'h3;
  localparam logic [3:0] OE_QUAD   = 4'hf;

  typedef enum logic [1:0] {W_SINGLE, W_DUAL, W_QUAD, W_DDR} sfi_width_t;

  typedef enum logic [3:0] {
    ST_POR, ST_WRESET, ST_STANDBY, ST_SLEEP, ST_WAKE, ST_INSTR,
    ST_ADDR, ST_MODE, ST_LATENCY, ST_OUTPUT, ST_WDATA
  } sfi_state_t;

  // bits moved per transfer
  function automatic logic [2:0] group_bits(input sfi_width_t w);
    case (w)
      W_SINGLE: group_bits = 3'h1;
      W_DUAL:   group_bits = 3'h2;
      default:  group_bits = 3'h4;
    endcase
  endfunction

  // shift a group in, lowest bit from line zero
  function automatic logic [31:0] shift_in(input logic [31:0] sr, input logic [3:0] ln,
                                           input sfi_width_t w);
    case (w)
      W_SINGLE: shift_in = {sr[30:0], ln[0]};
      W_DUAL:   shift_in = {sr[29:0], ln[1:0]};
      default:  shift_in = {sr[27:0], ln};
    endcase
  endfunction

  // top bits of a byte onto the lines; single output uses line one
  function automatic logic [3:0] drive_group(input logic [7:0] b, input sfi_width_t w);
    case (w)
      W_SINGLE: drive_group = {2'h0, b[7], 1'b0};
      W_DUAL:   drive_group = {2'h0, b[7:6]};
      default:  drive_group = b[7:4];
    endcase
  endfunction

  function automatic logic [3:0] lane_enable(input sfi_width_t w);
    case (w)
      W_SINGLE: lane_enable = OE_SINGLE;
      W_DUAL:   lane_enable = OE_DUAL;
      default:  lane_enable = OE_QUAD;
    endcase
  endfunction

endpackage : sfi_pkg

// >>> logic/sfi_sync.sv
// two-stage synchroniser for pins entering the core clock domain
`timescale 1ns/100ps
module sfi_sync #(
  parameter int WIDTH = 1
) (
  // clock, reset, enable
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  input  wire logic             clk_en_i,
  // levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      meta   <= '1;
      sync_o <= '1;
    end else if (clk_en_i) begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule // sfi_sync

// >>> logic/sfi_fifo.sv
// read data fifo, valid/ready on both sides, with flush
`timescale 1ns/100ps
module sfi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock, reset, enable
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  input  wire logic             clk_en_i,
  input  wire logic             flush_i,
  // fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // drain side
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;
  logic [AW:0]      next_count;

  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_valid_o = count != '0;
  assign out_data_o  = mem[rd_ptr];
  assign next_count  = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // ready is registered so it reaches the pin straight from a flop
  always_ff @(posedge core_clk_i) begin
    if (reset_i || (clk_en_i && flush_i)) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      in_ready_o <= 1'b1;
    end else if (clk_en_i) begin
      if (push) begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr      <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count      <= next_count;
      in_ready_o <= next_count != (AW+1)'(DEPTH);
    end
  end

  a_fifo_no_overrun: assert property (@(posedge core_clk_i) disable iff (reset_i)
    count == (AW+1)'(DEPTH) |-> !in_ready_o)
    else $error("fifo full yet ready");
endmodule // sfi_fifo

// >>> logic/sfi_core.sv
// serial flash interface state control, device side
`timescale 1ns/100ps
module sfi_core
  import sfi_pkg::*;
#(
  parameter int         PU_CYCLES       = PU_CYCLES_DEF,
  parameter int         RP_CYCLES       = RP_CYCLES_DEF,
  parameter int         RPH_CYCLES      = RPH_CYCLES_DEF,
  parameter int         RH_CYCLES       = RH_CYCLES_DEF,
  parameter int         RES_CYCLES      = RES_CYCLES_DEF,
  parameter logic [7:0] CMD_READ_SINGLE = 8'h03,
  parameter logic [7:0] CMD_READ_DUAL   = 8'hbb,
  parameter logic [7:0] CMD_READ_QUAD   = 8'heb,
  parameter logic [7:0] CMD_READ_DDR    = 8'hed
) (
  // clock, reset, enable
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic        clk_en_i,
  // serial link pins
  input  wire logic        cs_n_i,
  input  wire logic        sck_i,
  input  wire logic [3:0]  data_line_i,
  output logic      [3:0]  data_line_o,
  output logic      [3:0]  data_line_oe_o,
  // configuration and status
  input  wire logic        warm_reset_en_i,
  input  wire logic        quad_mode_i,
  input  wire logic        four_bit_instruction_mode_i,
  input  wire logic [3:0]  latency_i,
  input  wire logic        dlp_en_i,
  input  wire logic [7:0]  data_learning_pattern_i,
  input  wire logic        write_in_progress_flag_i,
  // read data stream
  input  wire logic        rd_valid_i,
  input  wire logic [7:0]  rd_data_i,
  output logic             rd_ready_o,
  // command results
  output logic      [7:0]  cmd_o,
  output logic             cmd_valid_o,
  output logic             cmd_reject_o,
  output logic      [7:0]  rx_byte_o,
  output logic             rx_byte_valid_o,
  output logic      [23:0] addr_o,
  output logic             read_start_o,
  output logic             deep_sleep_o,
  output sfi_state_t       state_o
);
  // ----------------------------------------------------------------
  // pin sampling and edge detection
  // ----------------------------------------------------------------
  logic       s_cs_n;
  logic       s_sck;
  logic [3:0] s_line;
  logic       sck_d;
  logic       cs_d;
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_fall;
  logic       cs_rise;

  // link clock is slow against the core clock, so plain sampling works
  sfi_sync #(.WIDTH(6)) u_sync (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .clk_en_i   (clk_en_i),
    .async_i    ({cs_n_i, sck_i, data_line_i}),
    .sync_o     ({s_cs_n, s_sck, s_line})
  );

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sck_d <= 1'b1;
      cs_d  <= 1'b1;
    end else if (clk_en_i) begin
      sck_d <= s_sck;
      cs_d  <= s_cs_n;
    end
  end

  assign sck_rise = s_sck & ~sck_d;
  assign sck_fall = ~s_sck & sck_d;
  assign cs_fall  = cs_d & ~s_cs_n;
  assign cs_rise  = ~cs_d & s_cs_n;

  // ----------------------------------------------------------------
  // state and datapath registers
  // ----------------------------------------------------------------
  sfi_state_t  state;
  sfi_width_t  wid;
  logic [23:0] tmr;
  logic [31:0] in_sr;
  logic [5:0]  ph_cnt;
  logic [2:0]  wd_cnt;
  logic [3:0]  lat_cnt;
  logic [2:0]  dlp_idx;
  logic [7:0]  out_sr;
  logic [3:0]  out_left;
  logic [15:0] lo_cnt;
  logic [15:0] hi_cnt;

  assign state_o = state;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  sfi_width_t  iw;
  sfi_width_t  cur_w;
  sfi_width_t  read_wid;
  logic [2:0]  gw;
  logic [31:0] next_in_sr;
  logic [5:0]  next_ph;
  logic [2:0]  next_wd;
  logic        in_cmd;
  logic        cap_evt;
  logic        drv_evt;
  logic        read_hit;
  logic        wdata_end;
  logic        bad_end;
  logic        out_go;
  logic [7:0]  out_src;
  logic        fifo_valid;
  logic [7:0]  fifo_data;
  logic        fifo_pop;
  logic        rst_line_low;
  logic        warm_hit;

  // instructions run four wide in four-bit mode, one wide otherwise
  assign iw         = four_bit_instruction_mode_i ? W_QUAD : W_SINGLE;
  assign cur_w      = (state == ST_ADDR || state == ST_MODE) ? wid : iw;
  assign gw         = group_bits(cur_w);
  assign next_in_sr = shift_in(in_sr, s_line, cur_w);
  assign next_ph    = ph_cnt + {3'h0, gw};
  assign next_wd    = wd_cnt + gw;
  assign in_cmd     = state inside {ST_INSTR, ST_ADDR, ST_MODE, ST_LATENCY, ST_OUTPUT, ST_WDATA};
  // ddr moves address, mode and data on both edges; the first address bit waits for a rising edge
  assign cap_evt    = (wid == W_DDR && !(state == ST_ADDR && ph_cnt == 6'h0)) ? (sck_rise | sck_fall) : sck_rise;
  assign drv_evt    = (wid == W_DDR) ? (sck_rise | sck_fall) : sck_fall;

  // read commands and their width; none while asleep
  assign read_hit = !deep_sleep_o && (next_in_sr[7:0] inside
                    {CMD_READ_SINGLE, CMD_READ_DUAL, CMD_READ_QUAD, CMD_READ_DDR});
  assign read_wid = (next_in_sr[7:0] == CMD_READ_SINGLE) ? W_SINGLE :
                    (next_in_sr[7:0] == CMD_READ_DUAL)   ? W_DUAL   :
                    (next_in_sr[7:0] == CMD_READ_QUAD)   ? W_QUAD   : W_DDR;

  // end-of-command checks on the bit count since select fell
  assign wdata_end = (state == ST_WDATA) && (wd_cnt == 3'h0);
  assign bad_end   = (state == ST_INSTR && ph_cnt != 6'h0) ||
                     (state == ST_WDATA && wd_cnt != 3'h0);

  // first data leaves on the falling edge ending the last latency cycle
  assign out_go   = (state == ST_OUTPUT && drv_evt) ||
                    (state == ST_LATENCY && sck_fall && lat_cnt == 4'h0);
  assign out_src  = (out_left != 4'h0) ? out_sr : (fifo_valid ? fifo_data : PAD_BYTE);
  assign fifo_pop = out_go && out_left == 4'h0 && fifo_valid;

  // line three as reset: only with select high while in quad or four-bit instruction mode
  assign rst_line_low = ~s_line[3] & warm_reset_en_i & (state != ST_POR) &
                        (~(quad_mode_i | four_bit_instruction_mode_i) | s_cs_n);
  assign warm_hit     = rst_line_low && lo_cnt == 16'(RP_CYCLES - 1);

  // ----------------------------------------------------------------
  // read data buffer
  // ----------------------------------------------------------------
  // source stalls on rd_ready_o; an empty buffer pads the output
  sfi_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .clk_en_i    (clk_en_i),
    .flush_i     ((in_cmd && cs_rise) || warm_hit),
    .in_valid_i  (rd_valid_i),
    .in_data_i   (rd_data_i),
    .in_ready_o  (rd_ready_o),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (fifo_pop)
  );

  // ----------------------------------------------------------------
  // reset line pulse and hold counters
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      lo_cnt <= 16'h0;
      hi_cnt <= 16'h0;
    end else if (clk_en_i) begin
      // saturating, so one long pulse fires only once
      if (!rst_line_low) begin
        lo_cnt <= 16'h0;
      end else if (lo_cnt != 16'(RP_CYCLES)) begin
        lo_cnt <= lo_cnt + 16'h1;
      end
      if (!s_line[3]) begin
        hi_cnt <= 16'h0;
      end else if (hi_cnt != 16'(RH_CYCLES)) begin
        hi_cnt <= hi_cnt + 16'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // interface state machine
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state           <= ST_POR;
      wid             <= W_SINGLE;
      tmr             <= 24'(PU_CYCLES - 1);
      in_sr           <= 32'h0;
      ph_cnt          <= 6'h0;
      wd_cnt          <= 3'h0;
      lat_cnt         <= 4'h0;
      dlp_idx         <= 3'h7;
      out_sr          <= 8'h0;
      out_left        <= 4'h0;
      data_line_o     <= 4'h0;
      data_line_oe_o  <= OE_NONE;
      cmd_o           <= 8'h0;
      cmd_valid_o     <= 1'b0;
      cmd_reject_o    <= 1'b0;
      rx_byte_o       <= 8'h0;
      rx_byte_valid_o <= 1'b0;
      addr_o          <= 24'h0;
      read_start_o    <= 1'b0;
      deep_sleep_o    <= 1'b0;
    end else if (clk_en_i) begin
      cmd_valid_o     <= 1'b0;
      cmd_reject_o    <= 1'b0;
      rx_byte_valid_o <= 1'b0;
      read_start_o    <= 1'b0;
      if (warm_hit) begin
        // reset process runs, then waits for the hold after the rise
        state          <= ST_WRESET;
        tmr            <= 24'(RPH_CYCLES - 1);
        deep_sleep_o   <= 1'b0;
        data_line_oe_o <= OE_NONE;
      end else if (in_cmd && cs_rise) begin
        data_line_oe_o <= OE_NONE;
        state          <= deep_sleep_o ? ST_SLEEP : ST_STANDBY;
        if (wdata_end && deep_sleep_o && cmd_o == CMD_WAKE) begin
          state <= ST_WAKE;
          tmr   <= 24'(RES_CYCLES - 1);
        end else if (wdata_end && !deep_sleep_o && cmd_o == CMD_SLEEP &&
                     !write_in_progress_flag_i) begin
          state        <= ST_SLEEP;
          deep_sleep_o <= 1'b1;
          cmd_valid_o  <= 1'b1;
        end else if (wdata_end && !deep_sleep_o && cmd_o != CMD_SLEEP) begin
          cmd_valid_o <= 1'b1;
        end else if (!deep_sleep_o && (bad_end || wdata_end)) begin
          cmd_reject_o <= 1'b1;
        end
      end else begin
        if (out_go) begin
          // new byte from the buffer, or the pad byte when it is empty, whenever the last one is spent
          state          <= ST_OUTPUT;
          data_line_o    <= drive_group(out_src, wid);
          data_line_oe_o <= lane_enable(wid);
          out_sr         <= out_src << gw;
          out_left       <= ((out_left == 4'h0) ? 4'h8 : out_left) - {1'b0, gw};
        end
        case (state)
          ST_POR, ST_WAKE: begin
            // silent until the interval runs out
            if (tmr == 24'h0) begin
              state        <= ST_STANDBY;
              deep_sleep_o <= 1'b0;
            end else begin
              tmr <= tmr - 24'h1;
            end
          end
          ST_WRESET: begin
            if (tmr != 24'h0) begin
              tmr <= tmr - 24'h1;
            end else if (hi_cnt == 16'(RH_CYCLES)) begin
              state <= ST_STANDBY;
            end
          end
          ST_STANDBY, ST_SLEEP: begin
            // everything but select and the reset line is ignored here
            if (cs_fall) begin
              state  <= ST_INSTR;
              ph_cnt <= 6'h0;
            end
          end
          ST_INSTR: begin
            if (sck_rise) begin
              in_sr  <= next_in_sr;
              ph_cnt <= next_ph;
              if (next_ph == INSTR_BITS) begin
                cmd_o    <= next_in_sr[7:0];
                ph_cnt   <= 6'h0;
                wd_cnt   <= 3'h0;
                out_left <= 4'h0;
                wid      <= read_hit ? read_wid : W_SINGLE;
                state    <= read_hit ? ST_ADDR : ST_WDATA;
              end
            end
          end
          ST_ADDR: begin
            if (cap_evt) begin
              in_sr  <= next_in_sr;
              ph_cnt <= next_ph;
              if (next_ph == ADDR_BITS) begin
                addr_o <= next_in_sr[23:0];
                ph_cnt <= 6'h0;
                if (wid == W_SINGLE) begin
                  state        <= ST_LATENCY;
                  lat_cnt      <= 4'h0;
                  read_start_o <= 1'b1;
                end else begin
                  state <= ST_MODE;
                end
              end
            end
          end
          ST_MODE: begin
            if (cap_evt) begin
              in_sr  <= next_in_sr;
              ph_cnt <= next_ph;
              if (next_ph == MODE_BITS) begin
                state        <= ST_LATENCY;
                lat_cnt      <= latency_i;
                dlp_idx      <= 3'h7;
                read_start_o <= 1'b1;
              end
            end
          end
          ST_LATENCY: begin
            // sdr latency: lines stay undriven, samples are dropped
            if (!out_go && sck_fall) begin
              lat_cnt <= lat_cnt - 4'h1;
            end
            // ddr latency may carry the learning pattern, msb first
            if (!out_go && wid == W_DDR && dlp_en_i && (sck_rise | sck_fall)) begin
              data_line_o    <= {4{data_learning_pattern_i[dlp_idx]}};
              data_line_oe_o <= OE_QUAD;
              dlp_idx        <= dlp_idx - 3'h1;
            end
          end
          ST_OUTPUT: begin
            // stays here until select rises or a warm reset hits
          end
          ST_WDATA: begin
            if (sck_rise) begin
              in_sr  <= next_in_sr;
              wd_cnt <= next_wd;
              if (next_wd == 3'h0 && !deep_sleep_o) begin
                rx_byte_o       <= next_in_sr[7:0];
                rx_byte_valid_o <= 1'b1;
              end
            end
          end
          default: begin
            state <= ST_STANDBY;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i || !clk_en_i);

  a_idle_no_drive: assert property (!in_cmd |-> data_line_oe_o == OE_NONE)
    else $error("lines driven outside a command");
  a_latency_float: assert property (state == ST_LATENCY && wid != W_DDR |->
    data_line_oe_o == OE_NONE)
    else $error("lines driven in sdr latency");
  a_single_out_lane: assert property (state == ST_OUTPUT && wid == W_SINGLE |->
    data_line_oe_o == OE_SINGLE)
    else $error("single output uses wrong lanes");
  a_dual_out_lane: assert property (state == ST_OUTPUT && wid == W_DUAL |->
    data_line_oe_o == OE_DUAL)
    else $error("dual output uses wrong lanes");
  a_select_high_idle: assert property (in_cmd && cs_rise && !warm_hit |=> !in_cmd)
    else $error("command survived select rising");
  a_instr_start: assert property (state == ST_STANDBY && cs_fall && !warm_hit |=>
    state == ST_INSTR)
    else $error("select fall did not start instruction");
  a_sleep_entry: assert property (!deep_sleep_o ##1 deep_sleep_o |->
    !$past(write_in_progress_flag_i))
    else $error("sleep entered while busy");
  a_sleep_quiet: assert property (deep_sleep_o && $past(deep_sleep_o) |->
    !cmd_valid_o && !read_start_o)
    else $error("command acted on while asleep");
  a_wake_delay: assert property (state == ST_WAKE && !warm_hit ##1 state == ST_STANDBY |->
    $past(tmr) == 24'h0)
    else $error("wake left before its delay");
endmodule // sfi_core

// >>> bench/sfi_host_model.sv
// host side model: drives select, serial clock and lines, collects line one
`timescale 1ns/100ps
module sfi_host_model (
  // clock
  input  wire logic       core_clk_i,
  // link
  input  wire logic [3:0] line_i,
  output logic            cs_n_o,
  output logic            sck_o,
  output logic      [3:0] line_o
);
  logic [63:0] rx     = 64'h0;
  logic [3:0]  flip   = 4'h5;
  logic        rst_n  = 1'b1;
  logic        drv    = 1'b0;
  logic        d0     = 1'b0;
  logic        quad   = 1'b0;
  logic [3:0]  nib    = 4'h0;
  initial cs_n_o = 1'b1;
  initial sck_o  = 1'b0;
  // released lines toggle so a stale level never passes as data
  always @(posedge core_clk_i) flip <= ~flip;
  assign line_o = (drv && quad) ? nib : {rst_n, flip[2:1], drv ? d0 : flip[0]};
  // half of an 80 ns link period
  task automatic half();
    repeat (5) @(posedge core_clk_i);
    #1;
  endtask
  // one frame, msb first on line zero, or a nibble a clock with quad set; clock still outside frames
  task automatic frame(input int n, input logic [63:0] bits);
    cs_n_o = 1'b0;
    drv    = 1'b1;
    half();
    for (int i = 0; i < n; i++) begin
      d0 = bits[n-1-i];
      if (quad) nib = bits[4*(n-i)-1 -: 4];
      half();
      sck_o = 1'b1;
      rx    = {rx[62:0], line_i[1]};
      half();
      sck_o = 1'b0;
    end
    half();
    cs_n_o = 1'b1;
    drv    = 1'b0;
    repeat (2) half();
  endtask
  // reset line low; select high as quad mode needs, or low to show the refusal
  task automatic pulse_reset(input logic sel);
    cs_n_o = ~sel;
    rst_n  = 1'b0;
    repeat (32) @(posedge core_clk_i);
    #1;
    rst_n  = 1'b1;
    cs_n_o = 1'b1;
  endtask
endmodule // sfi_host_model

// >>> bench/tb_sfi_core.sv
// testbench: power-up, fifo fill, read, framing, sleep and warm reset
`timescale 1ns/100ps
module tb_sfi_core;
  import sfi_pkg::*;
  logic core_clk_i = 0, reset_i = 1, write_in_progress_flag = 1, wr_en = 0, rd_valid = 0, cmd_v, cmd_r, rx_v, rs, ds, rdy;
  logic [7:0]  rd_data = 8'h00, pat = 8'ha5, cmd, rx_b, last_rx = 8'h00;
  logic [3:0]  line_i, d_o, d_oe, host_d, lat = 4'h0;
  logic [23:0] addr;
  logic        cs_n, sck;
  logic        ce = 1'b1, fb = 1'b0, qm = 1'b0;
  sfi_state_t  st;
  int          fail_count = 0, tests_run = 0, cyc = 0, n_ok = 0, n_rej = 0;
  always #4 core_clk_i = ~core_clk_i;
  assign line_i = (d_oe & d_o) | (~d_oe & host_d);
  sfi_host_model u_sfi_host_model (.core_clk_i(core_clk_i), .line_i(line_i), .cs_n_o(cs_n), .sck_o(sck),
    .line_o(host_d));
  sfi_core #(.PU_CYCLES(20), .RPH_CYCLES(10), .RES_CYCLES(10)) u_sfi_core (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .clk_en_i(ce), .cs_n_i(cs_n), .sck_i(sck),
    .data_line_i(line_i), .data_line_o(d_o), .data_line_oe_o(d_oe), .warm_reset_en_i(wr_en),
    .quad_mode_i(qm), .four_bit_instruction_mode_i(fb), .latency_i(lat), .dlp_en_i(1'b0),
    .data_learning_pattern_i(pat), .write_in_progress_flag_i(write_in_progress_flag), .rd_valid_i(rd_valid),
    .rd_data_i(rd_data), .rd_ready_o(rdy), .cmd_o(cmd), .cmd_valid_o(cmd_v), .cmd_reject_o(cmd_r),
    .rx_byte_o(rx_b), .rx_byte_valid_o(rx_v), .addr_o(addr), .read_start_o(rs), .deep_sleep_o(ds),
    .state_o(st));
  // pulses are one cycle wide, so tally them as they pass
  always @(posedge core_clk_i) begin
    cyc = cyc + 1;
    if (cmd_v === 1'b1) n_ok = n_ok + 1;
    if (cmd_r === 1'b1) n_rej = n_rej + 1;
    if (rx_v === 1'b1) last_rx = rx_b;
    if (cyc > 30000) begin
      fail_count = fail_count + 1;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait for a state, then compare it
  task automatic wait_st(input sfi_state_t s);
    for (int k = 0; k < 400 && st !== s; k++) @(posedge core_clk_i);
    #1;
    chk(32'(st), 32'(s));
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk_i);
    #1;
    reset_i = 1'b0;
    repeat (10) @(posedge core_clk_i);
    #1;
    chk(32'(st), 32'(ST_POR));
    chk(32'(d_oe), 32'h0);
    wait_st(ST_STANDBY);
    // frozen core ignores a whole frame
    ce = 1'b0;
    u_sfi_host_model.frame(8, 64'h06);
    ce = 1'b1;
    chk(32'(n_ok), 32'h0);
    chk(32'(st), 32'(ST_STANDBY));
    // fill the fifo until it refuses
    rd_valid = 1'b1;
    for (int i = 0; i < 34; i++) begin
      rd_data = 8'(i);
      @(posedge core_clk_i);
      #1;
    end
    rd_valid = 1'b0;
    chk(32'(rdy), 32'h0);
    // single read returns two bytes to the host on line one, msb first
    u_sfi_host_model.frame(48, {8'h03, 24'h3c5a96, 16'h0});
    chk(32'(addr), 32'h3c5a96);
    chk(32'(u_sfi_host_model.rx[15:0]), 32'h0001);
    chk(32'(d_oe), 32'h0);
    chk(32'(rdy), 32'h1);
    // write byte on a boundary, then a broken frame
    u_sfi_host_model.frame(16, {48'h0, 8'h06, 8'h5a});
    chk(32'(n_ok), 32'h1);
    chk(32'(last_rx), 32'h5a);
    u_sfi_host_model.frame(12, 64'h0c3);
    chk(32'(n_rej), 32'h1);
    chk(32'(cmd), 32'h0c);
    // sleep refused while busy, taken when idle
    u_sfi_host_model.frame(8, 64'hb9);
    chk(32'(n_rej), 32'h2);
    chk(32'(ds), 32'h0);
    write_in_progress_flag = 1'b0;
    u_sfi_host_model.frame(8, 64'hb9);
    wait_st(ST_SLEEP);
    u_sfi_host_model.frame(16, 64'h065a);
    chk(32'(n_ok), 32'h2);
    chk(32'(ds), 32'h1);
    u_sfi_host_model.frame(8, 64'hab);
    wait_st(ST_STANDBY);
    chk(32'(ds), 32'h0);
    // four-bit instruction arrives as two nibbles, upper first
    fb = 1'b1;
    u_sfi_host_model.quad = 1'b1;
    u_sfi_host_model.frame(2, 64'h06);
    u_sfi_host_model.quad = 1'b0;
    chk(32'(cmd), 32'h06);
    chk(32'(n_ok), 32'h3);
    // reset line ignored until enabled, refused with select low in four-bit mode, then honoured
    u_sfi_host_model.pulse_reset(1'b0);
    chk(32'(st), 32'(ST_STANDBY));
    wr_en = 1'b1;
    u_sfi_host_model.pulse_reset(1'b1);
    chk(32'(st), 32'(ST_INSTR));
    wait_st(ST_STANDBY);
    fb = 1'b0;
    qm = 1'b1;
    u_sfi_host_model.pulse_reset(1'b0);
    chk(32'(st), 32'(ST_WRESET));
    chk(32'(d_oe), 32'h0);
    wait_st(ST_STANDBY);
    wrap_up();
  end
endmodule // tb_sfi_core
